// ==== logic/lsu_map.vh ====
// What this block does
// - Missing immediate offset means base address alone.
// - Unsigned byte/half loads zero-extend to 32 bits.
// - Stores write word, low byte or low half.
// - Immediate address is base or stack plus offset.
// - Memory instructions never change condition flags.
// - Register-offset forms add sign-extending loads.
// - Register-offset address is base plus offset.
// - Multi transfer: ascending registers, four-byte steps.
// - Writeback stores base plus four times count.
// - Push ends below stack pointer, lowers it.
// - Pop starts at stack pointer, raises it.
// - Pop into counter branches; bit zero sets state.
// - Alias names decode to multi load/store.
// - Misaligned address raises hard fault, no access.
// - Counter-relative base is instruction address plus four.
`ifndef LSU_MAP_VH
`define LSU_MAP_VH
// Instruction kinds presented on the kind port.
`define LSU_KIND_IMM 3'h0
`define LSU_KIND_REG 3'h1
`define LSU_KIND_PCREL 3'h2
`define LSU_KIND_MULTI_LOAD 3'h3
`define LSU_KIND_MULTI_STORE 3'h4
`define LSU_KIND_PUSH 3'h5
`define LSU_KIND_POP 3'h6
// Alias spellings share the plain multi transfer codes.
`define LSU_KIND_MULTI_LOAD_INC_AFTER_ALIAS `LSU_KIND_MULTI_LOAD
`define LSU_KIND_MULTI_LOAD_FULL_DESC_ALIAS `LSU_KIND_MULTI_LOAD
`define LSU_KIND_MULTI_STORE_INC_AFTER_ALIAS `LSU_KIND_MULTI_STORE
`define LSU_KIND_MULTI_STORE_EMPTY_ASC_ALIAS `LSU_KIND_MULTI_STORE
// Transfer sizes.
`define LSU_SZ_BYTE 2'h0
`define LSU_SZ_HALF 2'h1
`define LSU_SZ_WORD 2'h2
// Register indices of the special registers.
`define LSU_IDX_SP 4'hD
`define LSU_IDX_LR 4'hE
`define LSU_IDX_PC 4'hF
// Address offsets and steps.
`define LSU_PC_AHEAD 32'h00000004
`define LSU_WORD_STEP 32'h00000004
`define LSU_ZERO_WORD 32'h00000000
// Byte enables of a full word.
`define LSU_BE_WORD 4'hF
`endif

// ==== logic/lsu_lane.v ====
`timescale 1ns/1ps
`default_nettype none
`include "lsu_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Byte lane steering for stores and extension for loads (little-endian).
module lsu_lane
(
  input wire [1:0] size,
  input wire sign_ext,
  input wire [1:0] addr_lo,
  input wire [31:0] st_val,
  input wire [31:0] ld_raw,
  output reg [3:0] be,
  output reg [31:0] wdata,
  output reg [31:0] ld_val
);

  // Raw lane contents picked by the low address bits.
  reg [7:0] ld_byte;
  reg [15:0] ld_half;

  ////////////////////////////////////////////////////////////////////////////////
  // Store side: only the low byte or low half of the source is replicated
  // onto every lane, and only the addressed lanes are enabled.
  always @*
  begin
    case (size)
      `LSU_SZ_BYTE:
      begin
        wdata = {4{st_val[7:0]}};
        be = 4'h1 << addr_lo;
      end
      `LSU_SZ_HALF:
      begin
        wdata = {2{st_val[15:0]}};
        be = addr_lo[1] ? 4'hC : 4'h3;
      end
      default:
      begin
        wdata = st_val;
        be = `LSU_BE_WORD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Load side: pick the lane, then zero- or sign-extend to a word.
  always @*
  begin
    ld_byte = ld_raw[8*addr_lo +: 8];
    ld_half = addr_lo[1] ? ld_raw[31:16] : ld_raw[15:0];
    case (size)
      `LSU_SZ_BYTE:
        ld_val = sign_ext ? {{24{ld_byte[7]}}, ld_byte} : {24'h000000, ld_byte};
      `LSU_SZ_HALF:
        ld_val = sign_ext ? {{16{ld_half[15]}}, ld_half} : {16'h0000, ld_half};
      default:
        ld_val = ld_raw;
    endcase
  end

endmodule // lsu_lane
`default_nettype wire

// ==== logic/lsu_load_store_unit.v ====
`timescale 1ns/1ps
`default_nettype none
`include "lsu_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Load/store execution unit. The core hands over one decoded memory
// instruction per start pulse; the unit walks the data bus, writes loaded
// values back through a register write port and reports done or a fault.
module lsu_load_store_unit
(
  input wire clk,
  input wire rst,
  input wire start,
  input wire [2:0] kind,
  input wire [1:0] size,
  input wire sign_ext,
  input wire is_load,
  input wire sp_base,
  input wire imm_present,
  input wire [31:0] imm,
  input wire [2:0] transfer_reg,
  input wire [2:0] base_reg,
  input wire [31:0] base_val,
  input wire [31:0] offset_val,
  input wire [31:0] stack_pointer,
  input wire [31:0] program_counter,
  input wire [7:0] reg_list,
  input wire list_link_register,
  input wire list_program_counter,
  input wire writeback,
  output wire [3:0] rd_idx,
  input wire [31:0] rd_data,
  output wire busy,
  output reg done_ff,
  output reg hard_fault_exception_ff,
  output reg wr_en_ff,
  output reg [3:0] wr_idx_ff,
  output reg [31:0] wr_data_ff,
  output reg branch_en_ff,
  output reg [31:0] branch_target_ff,
  output reg thumb_bit_ff,
  output wire flags_we,
  output wire mem_req,
  output reg mem_we_ff,
  output reg [31:0] mem_addr_ff,
  output reg [3:0] mem_be_ff,
  output reg [31:0] mem_wdata_ff,
  input wire [31:0] mem_rdata,
  input wire mem_ready
);

  // Sequencer states.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PREP = 2'h1;
  localparam [1:0] ST_ACC = 2'h2;
  localparam [1:0] ST_FIN = 2'h3;

  reg [1:0] state_ff; // Sequencer state.
  reg [1:0] size_ff; // Size of the access in flight.
  reg sext_ff; // Sign extension of the access in flight.
  reg load_ff; // High when the instruction reads memory.
  reg [15:0] mask_ff; // Registers still to transfer, one bit each.
  reg wb_en_ff; // Base or stack pointer update pending.
  reg [3:0] wb_idx_ff; // Register that receives the update.
  reg [31:0] wb_val_ff; // Updated base value.
  reg pop_pc_ff; // A counter value was popped.
  reg [31:0] pc_load_ff; // The popped counter value.

  // Values of the request being taken.
  reg [15:0] nxt_mask;
  reg [31:0] nxt_addr;
  reg [31:0] span;
  reg [31:0] nxt_wb_val;
  reg nxt_wb_en;
  reg [3:0] nxt_wb_idx;
  reg [1:0] nxt_size;
  reg nxt_load;
  reg misaligned;
  reg [4:0] count;
  reg [3:0] cur_idx;
  integer i; // Index of the lowest-pending search.
  // Index of the register count. Each loop has its own index; one shared index
  // would let the two combinational processes wake each other without end.
  integer k;

  // Lane module outputs.
  wire [3:0] lane_be;
  wire [31:0] lane_wdata;
  wire [31:0] lane_ld;

  // Remaining mask once the current register is done.
  wire [15:0] rest_mask = mask_ff & ~(16'h0001 << cur_idx);

  ////////////////////////////////////////////////////////////////////////////////
  // The flags port is never written by this unit.
  assign flags_we = 1'b0;
  assign busy = (state_ff != ST_IDLE);
  assign mem_req = (state_ff == ST_ACC);
  assign rd_idx = cur_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Lowest register still pending; transfers go in ascending order.
  always @*
  begin
    cur_idx = 4'h0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      if (mask_ff[i])
        cur_idx = i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of a new request: first address, register mask, writeback.
  // Only the first address is checked for alignment; later ones step by a
  // whole word from an aligned start and cannot go wrong.
  always @*
  begin
    nxt_mask = {list_program_counter, list_link_register, 6'h00, reg_list};
    count = 5'h00;
    for (k = 0; k < 16; k = k + 1)
      count = count + {4'h0, nxt_mask[k]};
    span = {25'h0000000, count, 2'h0};
    nxt_size = `LSU_SZ_WORD;
    nxt_load = 1'b1;
    nxt_wb_en = 1'b0;
    nxt_wb_idx = {1'b0, base_reg};
    nxt_wb_val = base_val + span;
    nxt_addr = base_val;
    case (kind)
      `LSU_KIND_IMM:
      begin
        nxt_mask = 16'h0001 << transfer_reg;
        nxt_addr = (sp_base ? stack_pointer : base_val)
                   + (imm_present ? imm : `LSU_ZERO_WORD);
        nxt_size = size;
        nxt_load = is_load;
      end
      `LSU_KIND_REG:
      begin
        nxt_mask = 16'h0001 << transfer_reg;
        nxt_addr = base_val + offset_val;
        nxt_size = size;
        nxt_load = is_load;
      end
      `LSU_KIND_PCREL:
      begin
        nxt_mask = 16'h0001 << transfer_reg;
        nxt_addr = program_counter + `LSU_PC_AHEAD + imm;
      end
      `LSU_KIND_MULTI_LOAD:
        nxt_wb_en = writeback;
      `LSU_KIND_MULTI_STORE:
      begin
        nxt_load = 1'b0;
        nxt_wb_en = writeback;
      end
      `LSU_KIND_PUSH:
      begin
        nxt_load = 1'b0;
        nxt_addr = stack_pointer - span;
        nxt_wb_en = 1'b1;
        nxt_wb_idx = `LSU_IDX_SP;
        nxt_wb_val = stack_pointer - span;
      end
      `LSU_KIND_POP:
      begin
        nxt_addr = stack_pointer;
        nxt_wb_en = 1'b1;
        nxt_wb_idx = `LSU_IDX_SP;
        nxt_wb_val = stack_pointer + span;
      end
      default:
        nxt_mask = 16'h0000;
    endcase
    case (nxt_size)
      `LSU_SZ_BYTE: misaligned = 1'b0;
      `LSU_SZ_HALF: misaligned = nxt_addr[0];
      default: misaligned = (nxt_addr[1:0] != 2'h0);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lane steering for the access in flight.
  lsu_lane u_lane
  (
    .size(size_ff),
    .sign_ext(sext_ff),
    .addr_lo(mem_addr_ff[1:0]),
    .st_val(rd_data),
    .ld_raw(mem_rdata),
    .be(lane_be),
    .wdata(lane_wdata),
    .ld_val(lane_ld)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer. The register write port carries loads one per beat and the
  // base update in the finishing cycle, so the update always lands last.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      size_ff <= `LSU_SZ_WORD;
      sext_ff <= 1'b0;
      load_ff <= 1'b0;
      mask_ff <= 16'h0000;
      wb_en_ff <= 1'b0;
      wb_idx_ff <= 4'h0;
      wb_val_ff <= 32'h00000000;
      pop_pc_ff <= 1'b0;
      pc_load_ff <= 32'h00000000;
      done_ff <= 1'b0;
      hard_fault_exception_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      wr_idx_ff <= 4'h0;
      wr_data_ff <= 32'h00000000;
      branch_en_ff <= 1'b0;
      branch_target_ff <= 32'h00000000;
      thumb_bit_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 32'h00000000;
      mem_be_ff <= 4'h0;
      mem_wdata_ff <= 32'h00000000;
    end
    else
    begin
      // Pulses last one cycle unless set again below.
      done_ff <= 1'b0;
      hard_fault_exception_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      branch_en_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (start)
          begin
            if (misaligned)
            begin
              // No bus access is made for a misaligned request.
              hard_fault_exception_ff <= 1'b1;
              done_ff <= 1'b1;
            end
            else if (nxt_mask != 16'h0000)
            begin
              // An empty list is an illegal encoding and is simply dropped.
              state_ff <= ST_PREP;
              mask_ff <= nxt_mask;
              mem_addr_ff <= nxt_addr;
              size_ff <= nxt_size;
              sext_ff <= sign_ext & (kind == `LSU_KIND_REG);
              load_ff <= nxt_load;
              wb_en_ff <= nxt_wb_en;
              wb_idx_ff <= nxt_wb_idx;
              wb_val_ff <= nxt_wb_val;
              pop_pc_ff <= 1'b0;
            end
          end
        end
        ST_PREP:
        begin
          // Store data is captured here so the bus sees registered values.
          mem_we_ff <= ~load_ff;
          mem_be_ff <= load_ff ? `LSU_BE_WORD : lane_be;
          mem_wdata_ff <= lane_wdata;
          state_ff <= ST_ACC;
        end
        ST_ACC:
        begin
          if (mem_ready)
          begin
            if (load_ff && (cur_idx == `LSU_IDX_PC))
            begin
              pop_pc_ff <= 1'b1;
              pc_load_ff <= mem_rdata;
            end
            else if (load_ff)
            begin
              wr_en_ff <= 1'b1;
              wr_idx_ff <= cur_idx;
              wr_data_ff <= lane_ld;
            end
            mask_ff <= rest_mask;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= mem_addr_ff + `LSU_WORD_STEP;
            state_ff <= (rest_mask != 16'h0000) ? ST_PREP : ST_FIN;
          end
        end
        ST_FIN:
        begin
          if (wb_en_ff)
          begin
            wr_en_ff <= 1'b1;
            wr_idx_ff <= wb_idx_ff;
            wr_data_ff <= wb_val_ff;
          end
          if (pop_pc_ff)
          begin
            // The branch waits until every pop beat is done and goes out with the update.
            branch_en_ff <= 1'b1;
            branch_target_ff <= {pc_load_ff[31:1], 1'b0};
            thumb_bit_ff <= pc_load_ff[0];
          end
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // lsu_load_store_unit
`default_nettype wire

// ==== verif/lsu_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Data memory behind the bus; answers each beat after lat wait cycles.
module lsu_mem_model
(
  input wire logic clk,
  input wire logic mem_req,
  input wire logic mem_we_ff,
  input wire logic [31:0] mem_addr_ff,
  input wire logic [3:0] mem_be_ff,
  input wire logic [31:0] mem_wdata_ff,
  input wire logic [2:0] lat,
  output logic [31:0] mem_rdata,
  output logic mem_ready
);
  logic [31:0] mem [0:63]; // Word array indexed by address bits 7:2.
  logic [2:0] cnt_ff; // Wait cycles already spent on this beat.
  initial
  begin
    mem_ready = 1'b0;
    mem_rdata = 32'h00000000;
    cnt_ff = 3'h0;
    for (int i = 0; i < 64; i++)
      mem[i] = 32'hC3A58100 + i;
  end
  // Read data toggles outside ready so a stale word can never pass.
  always @(posedge clk)
  begin
    if (mem_req && !mem_ready && cnt_ff == lat)
    begin
      mem_ready <= 1'b1;
      mem_rdata <= mem[mem_addr_ff[7:2]];
    end
    else
    begin
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_ff <= (mem_req && !mem_ready) ? cnt_ff + 3'h1 : 3'h0;
    end
    // Only enabled lanes are written, on the accepting edge.
    if (mem_req && mem_ready && mem_we_ff)
      for (int b = 0; b < 4; b++)
        if (mem_be_ff[b])
          mem[mem_addr_ff[7:2]][8*b+:8] <= mem_wdata_ff[8*b+:8];
  end
endmodule // lsu_mem_model
`default_nettype wire

// ==== verif/lsu_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lsu_map.vh"
////////////////////////////////////////////////////////////
// Port checks: first beat address, faults, bus hold and flags.
module lsu_props
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic busy,
  input wire logic [2:0] kind,
  input wire logic [1:0] size,
  input wire logic sp_base,
  input wire logic imm_present,
  input wire logic [31:0] imm,
  input wire logic [31:0] base_val,
  input wire logic [31:0] offset_val,
  input wire logic [31:0] stack_pointer,
  input wire logic [31:0] program_counter,
  input wire logic [7:0] reg_list,
  input wire logic list_link_register,
  input wire logic list_program_counter,
  input wire logic done_ff,
  input wire logic hard_fault_exception_ff,
  input wire logic flags_we,
  input wire logic mem_req,
  input wire logic mem_ready,
  input wire logic mem_we_ff,
  input wire logic [31:0] mem_addr_ff,
  input wire logic [3:0] mem_be_ff,
  input wire logic [31:0] mem_wdata_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Expected first addresses, worked out from the request fields.
  wire go = start && !busy;
  wire single = kind == `LSU_KIND_IMM || kind == `LSU_KIND_REG;
  wire [31:0] ia = (sp_base ? stack_pointer : base_val) + (imm_present ? imm : 32'h00000000);
  wire [31:0] sa = (kind == `LSU_KIND_IMM) ? ia : base_val + offset_val;
  wire ok = (size == `LSU_SZ_WORD) ? sa[1:0] == 2'h0 : (size == `LSU_SZ_HALF) ? !sa[0] : 1'b1;
  wire [31:0] pa = program_counter + `LSU_PC_AHEAD + imm;
  wire [3:0] n9 = 4'($countones({list_link_register, reg_list}));
  wire [31:0] pf = stack_pointer - {26'h0000000, n9, 2'h0};
  wire [31:0] fa = (kind == `LSU_KIND_POP) ? stack_pointer : base_val;
  wire multi = (|reg_list && (kind == `LSU_KIND_MULTI_LOAD || kind == `LSU_KIND_MULTI_STORE))
    || (kind == `LSU_KIND_POP && |{list_program_counter, reg_list});
  single_addr_a: assert property (
    go && single && ok |-> ##2 mem_req && mem_addr_ff == $past(sa, 2))
    else $error("single access address wrong");
  pcrel_addr_a: assert property (
    go && kind == `LSU_KIND_PCREL && pa[1:0] == 2'h0
    |-> ##2 mem_req && mem_addr_ff == $past(pa, 2))
    else $error("relative load address wrong");
  push_first_a: assert property (
    go && kind == `LSU_KIND_PUSH && n9 != 4'h0 && stack_pointer[1:0] == 2'h0
    |-> ##2 mem_req && mem_we_ff && mem_addr_ff == $past(pf, 2))
    else $error("push start address wrong");
  multi_first_a: assert property (
    go && multi && fa[1:0] == 2'h0 |-> ##2 mem_req && mem_addr_ff == $past(fa, 2))
    else $error("list transfer start address wrong");
  misalign_fault_a: assert property (
    go && single && !ok |=> hard_fault_exception_ff && done_ff && !mem_req)
    else $error("misaligned access not faulted");
  no_flags_a: assert property (!flags_we)
    else $error("flags written");
  bus_hold_a: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr_ff)
    && $stable(mem_wdata_ff) && $stable(mem_be_ff) && $stable(mem_we_ff))
    else $error("bus request changed before ready");
  done_idle_a: assert property (done_ff |-> !busy && !mem_req)
    else $error("done while still active");
endmodule // lsu_props
bind lsu_load_store_unit lsu_props u_props (.clk, .rst, .start, .busy, .kind, .size, .sp_base,
  .imm_present, .imm, .base_val, .offset_val, .stack_pointer, .program_counter, .reg_list,
  .list_link_register, .list_program_counter, .done_ff, .hard_fault_exception_ff, .flags_we,
  .mem_req, .mem_ready, .mem_we_ff, .mem_addr_ff, .mem_be_ff, .mem_wdata_ff);
`default_nettype wire

// ==== verif/tb_load_store_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lsu_map.vh"
////////////////////////////////////////////////////////////
module tb_load_store_unit;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, sx = 1'b0, ld = 1'b1, spb = 1'b0, ip = 1'b0;
  logic lr = 1'b0, pcl = 1'b0, wb = 1'b0;
  logic [2:0] kind = 3'h0, treg = 3'h0, breg = 3'h0, lat = 3'h0;
  logic [1:0] size = 2'h2;
  logic [31:0] imm = 32'h0, bv = 32'h0, ov = 32'h0, sp = 32'h0, pc = 32'h0, bt;
  logic [7:0] rl = 8'h00;
  logic [31:0] rf [0:15]; // Core register file answering rd_idx.
  logic [3:0] wi [0:15]; // Logged register writes of one instruction.
  logic [31:0] wd [0:15];
  logic tbit, f;
  int nw, num_errors = 0, n_checks = 0;
  wire [3:0] rd_idx, wr_idx_ff, mem_be_ff;
  wire [31:0] wr_data_ff, branch_target_ff, mem_addr_ff, mem_wdata_ff, mem_rdata;
  wire busy, done_ff, hf, wr_en_ff, branch_en_ff, thumb_bit_ff, mem_req, mem_we_ff, mem_ready;
  wire [31:0] rd_data = rf[rd_idx];
  always #10 clk = ~clk;
  lsu_load_store_unit DUT (.clk(clk), .rst(rst), .start(start), .kind(kind), .size(size),
    .sign_ext(sx), .is_load(ld), .sp_base(spb), .imm_present(ip), .imm(imm),
    .transfer_reg(treg), .base_reg(breg), .base_val(bv), .offset_val(ov), .stack_pointer(sp),
    .program_counter(pc), .reg_list(rl), .list_link_register(lr), .list_program_counter(pcl),
    .writeback(wb), .rd_idx(rd_idx), .rd_data(rd_data), .busy(busy), .done_ff(done_ff),
    .hard_fault_exception_ff(hf), .wr_en_ff(wr_en_ff), .wr_idx_ff(wr_idx_ff),
    .wr_data_ff(wr_data_ff), .branch_en_ff(branch_en_ff), .branch_target_ff(branch_target_ff),
    .thumb_bit_ff(thumb_bit_ff), .flags_we(), .mem_req(mem_req), .mem_we_ff(mem_we_ff),
    .mem_addr_ff(mem_addr_ff), .mem_be_ff(mem_be_ff), .mem_wdata_ff(mem_wdata_ff),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready));
  lsu_mem_model mdl (.clk(clk), .mem_req(mem_req), .mem_we_ff(mem_we_ff),
    .mem_addr_ff(mem_addr_ff), .mem_be_ff(mem_be_ff), .mem_wdata_ff(mem_wdata_ff), .lat(lat),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready));
  // Logs register writes and branches; sees last cycle's pulses.
  always @(posedge clk)
  begin
    if (wr_en_ff === 1'b1)
    begin
      wi[nw] = wr_idx_ff;
      wd[nw] = wr_data_ff;
      nw++;
    end
    if (branch_en_ff === 1'b1)
    begin
      bt = branch_target_ff;
      tbit = thumb_bit_ff;
    end
  end
  function automatic logic [31:0] m0(input int i);
    return 32'hC3A58100 + i;
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // One instruction: one-cycle start, bounded wait for done, one cycle more for the log.
  task automatic go(input logic [2:0] k);
    int n;
    n = 0;
    nw = 0;
    @(negedge clk);
    kind = k;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (done_ff !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    f = hf;
    chk("done", 32'h1, {31'h0, done_ff});
    @(negedge clk);
  endtask
  task automatic t_loads;
    treg = 3'h5;
    bv = 32'h10;
    imm = 32'h8;
    go(`LSU_KIND_IMM);
    chk("no offset", m0(4), wd[0]);
    chk("load idx", 32'h5, {28'h0, wi[0]});
    sp = 32'h20;
    spb = 1'b1;
    ip = 1'b1;
    imm = 32'h18;
    go(`LSU_KIND_IMM);
    chk("sp word", m0(14), wd[0]);
    spb = 1'b0;
    bv = 32'h20;
    imm = 32'h5;
    size = `LSU_SZ_BYTE;
    go(`LSU_KIND_IMM);
    chk("ubyte", 32'h81, wd[0]);
    ov = 32'h6;
    sx = 1'b1;
    size = `LSU_SZ_HALF;
    go(`LSU_KIND_REG);
    chk("shalf", 32'hFFFFC3A5, wd[0]);
    ov = 32'h5;
    size = `LSU_SZ_BYTE;
    go(`LSU_KIND_REG);
    chk("sbyte", 32'hFFFFFF81, wd[0]);
    imm = 32'h6;
    size = `LSU_SZ_HALF;
    go(`LSU_KIND_IMM);
    chk("uhalf", 32'h0000C3A5, wd[0]);
    pc = 32'h30;
    imm = 32'h8;
    go(`LSU_KIND_PCREL);
    chk("pcrel", m0(15), wd[0]);
    bv = 32'h12;
    ip = 1'b0;
    size = `LSU_SZ_WORD;
    go(`LSU_KIND_IMM);
    chk("fault", 32'h1, {31'h0, f});
    chk("fault writes", 32'h0, nw);
  endtask
  task automatic t_stores;
    logic [31:0] e; // Untouched memory word around a narrow store.
    ld = 1'b0;
    lat = 3'h2;
    treg = 3'h2;
    bv = 32'h40;
    ov = 32'h1;
    size = `LSU_SZ_BYTE;
    go(`LSU_KIND_REG);
    e = m0(16);
    chk("store byte", {e[31:16], rf[2][7:0], e[7:0]}, mdl.mem[16]);
    ov = 32'h6;
    size = `LSU_SZ_HALF;
    go(`LSU_KIND_REG);
    e = m0(17);
    chk("store half", {rf[2][15:0], e[15:0]}, mdl.mem[17]);
    bv = 32'h48;
    size = `LSU_SZ_WORD;
    go(`LSU_KIND_IMM);
    chk("sword", rf[2], mdl.mem[18]);
  endtask
  task automatic t_lists;
    lat = 3'h1;
    bv = 32'h80;
    rl = 8'h92;
    wb = 1'b1;
    go(`LSU_KIND_MULTI_LOAD_FULL_DESC_ALIAS);
    for (int j = 0; j < 3; j++)
      chk("mload", m0(32 + j), wd[j]);
    chk("mload base", 32'h8C, wd[3]);
    chk("mload idx", 32'h4, {28'h0, wi[1]});
    chk("mload base idx", 32'h0, {28'h0, wi[3]});
    bv = 32'hA0;
    rl = 8'h05;
    breg = 3'h3;
    go(`LSU_KIND_MULTI_STORE_EMPTY_ASC_ALIAS);
    chk("mstore", rf[0], mdl.mem[40]);
    chk("mstore", rf[2], mdl.mem[41]);
    chk("mstore base", 32'hA8, wd[0]);
    chk("mstore base idx", 32'h3, {28'h0, wi[0]});
    sp = 32'hC0;
    lr = 1'b1;
    go(`LSU_KIND_PUSH);
    chk("push link", rf[14], mdl.mem[47]);
    chk("push sp", 32'hB4, wd[nw-1]);
    chk("push sp idx", {28'h0, `LSU_IDX_SP}, {28'h0, wi[nw-1]});
    lr = 1'b0;
    pcl = 1'b1;
    rl = 8'h08;
    go(`LSU_KIND_POP);
    chk("pop r3", m0(48), wd[0]);
    chk("pop sp", 32'hC8, wd[nw-1]);
    chk("pop sp idx", {28'h0, `LSU_IDX_SP}, {28'h0, wi[nw-1]});
    chk("pop writes", 32'h2, nw);
    chk("branch", m0(49) & 32'hFFFFFFFE, bt);
    chk("tbit", 32'h1, {31'h0, tbit});
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 16; i++)
      rf[i] = 32'h5A3C9600 + i;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_loads();
    t_stores();
    t_lists();
    report_and_stop();
  end
  // Whole run needs about 140 cycles; this cuts a hang short.
  initial
  begin
    #40000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb_load_store_unit
`default_nettype wire
